// File: src/cpurs_core_regs.sv
// How it works
// - one 8-bit accumulator feeds the alu and takes its results
// - two 8-bit index registers for addressing or scratch data
// - second index register is used only right after the prefix command
// - interrupt entry and return never save or restore the second index
// - 16-bit instruction pointer handled as separate low and high bytes
// - registers reachable only through commands, not the data memory map
// - flags read ones in 7..5, then half, mask, negative, zero, carry
// - whole flags byte pushed and popped; each flag set, cleared or tested
// - add and add-with-carry set half flag on carry from bit 3 to 4
// - mask set on any interrupt entry or by software; trap ignores it
// - mask cleared, set, restored by return, tested by two branches
// - requests arriving while masked stay pending until unmasked
// - unmasking inside a handler services pending requests at once
// - negative flag copies bit 7 of every alu or data result
// - zero flag set when the result is zero, cleared otherwise
// - carry on overflow or borrow; software can set or clear it
// - carry also updated by bit test and by every shift or rotate
// - branch pairs on half, mask, negative, zero and carry flags
// - call uses two stack bytes, interrupt five, low pointer byte first
module cpurs_core_regs (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire cpurs_pkg::cpurs_cmd_t cmd_i,
    input  wire logic              irq_req,
    input  wire logic [15:0]       irq_target,
    input  wire logic [15:0]       trap_target,
    input  wire logic [7:0]        stack_rdata,
    output logic                   ready,
    output logic                   irq_ack,
    output logic                   branch_taken,
    output cpurs_pkg::cpurs_stk_t  stk_o,
    output logic [7:0]             acc_q,
    output logic [7:0]             index_x_q,
    output logic [7:0]             index_y_q,
    output logic [15:0]            instr_pointer,
    output logic [7:0]             flags_register
);
    import cpurs_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]   acc_reg, x_reg, y_reg, save_flags_reg;
    logic [15:0]  ip_reg, save_ip_reg;
    logic         h_reg, i_reg, n_reg, z_reg, c_reg, prefix_reg, pend_reg;
    logic         ready_reg, ack_reg, br_reg, pop_v1_reg, pop_v2_reg;
    logic [2:0]   slot1_reg, slot2_reg, cnt_reg, len_reg, base_reg;
    logic [5:0]   sp_reg;
    cpurs_state_t st_reg;
    cpurs_stk_t   stk_reg;

    // registers leave only through these ports, never via memory
    assign acc_q          = acc_reg;
    assign index_x_q      = x_reg;
    assign index_y_q      = y_reg;
    assign instr_pointer  = ip_reg;
    assign flags_register = {FLAGS_TOP, h_reg, i_reg, n_reg, z_reg, c_reg};
    assign ready          = ready_reg;
    assign irq_ack        = ack_reg;
    assign branch_taken   = br_reg;
    assign stk_o          = stk_reg;

    // ----------------------------------------------------------------
    // command decode and alu
    // ----------------------------------------------------------------
    logic       idle, accept, irq_go, int_entry, wr_res, upd_nz, upd_c, upd_h;
    logic       co, hc, cond_ok, cap;
    logic [7:0] opa, res, cap_data;
    logic [8:0] wide;
    logic [4:0] nib;
    logic [2:0] cap_slot;

    // a command always wins the boundary; interrupts take idle gaps
    assign idle      = (st_reg == ST_IDLE);
    assign accept    = idle & cmd_i.valid;
    assign irq_go    = idle & ~cmd_i.valid & pend_reg & ~i_reg;
    assign int_entry = irq_go | (accept & (cmd_i.op == OP_TRAP)); // trap ignores mask
    assign cap       = pop_v2_reg;
    assign cap_slot  = slot2_reg;
    assign cap_data  = stack_rdata;

    // operate on the register chosen by dst and the prefix flag
    always_comb begin
        opa    = (cmd_i.dst == DST_ACC) ? acc_reg : (prefix_reg ? y_reg : x_reg);
        wide   = {1'b0, opa};
        nib    = 5'h00;
        res    = opa;
        co     = c_reg;
        hc     = h_reg;
        wr_res = 1'b1;
        upd_nz = 1'b1;
        upd_c  = 1'b0;
        upd_h  = 1'b0;
        unique case (cmd_i.op)
            OP_ADD, OP_ADC: begin
                nib   = {1'b0, opa[3:0]} + {1'b0, cmd_i.operand[3:0]}
                      + {4'h0, (cmd_i.op == OP_ADC) & c_reg};
                wide  = {1'b0, opa} + {1'b0, cmd_i.operand}
                      + {8'h00, (cmd_i.op == OP_ADC) & c_reg};
                hc    = nib[4];
                upd_h = 1'b1;
                upd_c = 1'b1;
            end
            OP_SUB, OP_SBC: begin
                wide  = {1'b0, opa} - {1'b0, cmd_i.operand}
                      - {8'h00, (cmd_i.op == OP_SBC) & c_reg};
                upd_c = 1'b1;
            end
            OP_AND:  wide = {1'b0, opa & cmd_i.operand};
            OP_OR:   wide = {1'b0, opa | cmd_i.operand};
            OP_XOR:  wide = {1'b0, opa ^ cmd_i.operand};
            OP_LD:   wide = {1'b0, cmd_i.operand};
            OP_SLL:  begin wide = {opa[7], opa[6:0], 1'b0};  upd_c = 1'b1; end
            OP_SRL:  begin wide = {opa[0], 1'b0, opa[7:1]};  upd_c = 1'b1; end
            OP_RLC:  begin wide = {opa[7], opa[6:0], c_reg}; upd_c = 1'b1; end
            OP_RRC:  begin wide = {opa[0], c_reg, opa[7:1]}; upd_c = 1'b1; end
            OP_BTST: begin
                wide   = {cmd_i.operand[cmd_i.target[2:0]], opa};
                wr_res = 1'b0;
                upd_nz = 1'b0;
                upd_c  = 1'b1;
            end
            default: begin
                wr_res = 1'b0;
                upd_nz = 1'b0;
            end
        endcase
        res = wide[7:0];
        co  = upd_c ? wide[8] : c_reg; // borrow also lands in bit 8
    end

    // branch condition pairs
    always_comb begin
        unique case (cmd_i.cond)
            BRANCH_IF_NIBBLE_CARRY:    cond_ok = h_reg;
            BRANCH_IF_NO_NIBBLE_CARRY: cond_ok = ~h_reg;
            BRANCH_IF_MASKED:          cond_ok = i_reg;
            BRANCH_IF_UNMASKED:        cond_ok = ~i_reg;
            BRANCH_IF_NEGATIVE:        cond_ok = n_reg;
            BRANCH_IF_POSITIVE:        cond_ok = ~n_reg;
            BRANCH_IF_EQUAL:           cond_ok = z_reg;
            BRANCH_IF_NOT_EQUAL:       cond_ok = ~z_reg;
            BRANCH_IF_OVERFLOW:        cond_ok = c_reg;
            BRANCH_IF_NO_OVERFLOW:     cond_ok = ~c_reg;
            default:                   cond_ok = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // data registers
    // ----------------------------------------------------------------
    // accumulator and both index registers; the frame has no slot for y
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_reg <= DATA_RST;
            x_reg   <= DATA_RST;
            y_reg   <= DATA_RST;
        end else if (accept & wr_res) begin
            if (cmd_i.dst == DST_ACC) acc_reg <= res;
            else if (prefix_reg) y_reg <= res;
            else x_reg <= res;
        end else if (cap & (cap_slot == SLOT_ACC)) begin
            acc_reg <= cap_data;
        end else if (cap & (cap_slot == SLOT_X)) begin
            x_reg <= cap_data;
        end
    end

    // prefix lasts exactly one following command
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) prefix_reg <= 1'b0;
        else if (accept) prefix_reg <= (cmd_i.op == OP_PREFIX);
    end

    // ----------------------------------------------------------------
    // flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {h_reg, i_reg, n_reg, z_reg, c_reg} <= FLAGS_RST;
        end else if (int_entry) begin
            i_reg <= 1'b1;
        end else if (accept) begin
            if (upd_h) h_reg <= hc;
            if (upd_nz) begin
                n_reg <= res[7];
                z_reg <= (res == DATA_RST);
            end
            c_reg <= co;
            unique case (cmd_i.op)
                OP_SET_OVERFLOW:   c_reg <= 1'b1;
                OP_CLEAR_OVERFLOW: c_reg <= 1'b0;
                OP_MASK:           i_reg <= 1'b1;
                OP_UNMASK:         i_reg <= 1'b0;
                default:           ;
            endcase
        end else if (cap & (cap_slot == SLOT_FLAGS)) begin
            h_reg <= cap_data[H_BIT];
            i_reg <= cap_data[I_BIT];
            n_reg <= cap_data[N_BIT];
            z_reg <= cap_data[Z_BIT];
            c_reg <= cap_data[C_BIT];
        end
    end

    // a request is held until entry; a new one in the same cycle wins
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) pend_reg <= 1'b0;
        else if (irq_req) pend_reg <= 1'b1;
        else if (irq_go) pend_reg <= 1'b0;
    end

    // ----------------------------------------------------------------
    // instruction pointer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ip_reg <= IP_RST;
            br_reg <= 1'b0;
        end else begin
            br_reg <= accept & (cmd_i.op == OP_BRANCH) & cond_ok;
            if (irq_go) ip_reg <= irq_target;
            else if (accept) begin
                unique case (cmd_i.op)
                    OP_TRAP:           ip_reg <= trap_target;
                    OP_JUMP, OP_CALL:  ip_reg <= cmd_i.target;
                    OP_RET, OP_HANDLER_RETURN: ip_reg <= ip_reg;
                    OP_BRANCH: ip_reg <= ip_reg + 16'h0001
                        + (cond_ok ? {{8{cmd_i.operand[7]}}, cmd_i.operand} : 16'h0000);
                    default:           ip_reg <= ip_reg + 16'h0001;
                endcase
            end else if (cap & (cap_slot == SLOT_IPL)) begin
                ip_reg[7:0] <= cap_data;
            end else if (cap & (cap_slot == SLOT_IPH)) begin
                ip_reg[15:8] <= cap_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // stack sequencer
    // ----------------------------------------------------------------
    logic [2:0] push_slot;
    logic [7:0] push_data;
    assign push_slot = base_reg + cnt_reg;

    // frame slots: low ip, high ip, x, acc, flags; y is never framed
    always_comb begin
        unique case (push_slot)
            SLOT_IPL: push_data = save_ip_reg[7:0];
            SLOT_IPH: push_data = save_ip_reg[15:8];
            SLOT_X:   push_data = x_reg;
            SLOT_ACC: push_data = acc_reg;
            default:  push_data = save_flags_reg;
        endcase
    end

    // reads return one cycle after re, so pops run two beats past the last read
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg         <= ST_IDLE;
            cnt_reg        <= 3'h0;
            len_reg        <= 3'h0;
            base_reg       <= 3'h0;
            sp_reg         <= SP_RST;
            save_ip_reg    <= IP_RST;
            save_flags_reg <= DATA_RST;
            stk_reg        <= '0;
            pop_v1_reg     <= 1'b0;
            pop_v2_reg     <= 1'b0;
            slot1_reg      <= 3'h0;
            slot2_reg      <= 3'h0;
            ready_reg      <= 1'b0;
            ack_reg        <= 1'b0;
        end else begin
            stk_reg.we <= 1'b0;
            stk_reg.re <= 1'b0;
            pop_v1_reg <= 1'b0;
            pop_v2_reg <= pop_v1_reg;
            slot2_reg  <= slot1_reg;
            ack_reg    <= irq_go;
            cnt_reg    <= 3'h0;
            unique case (st_reg)
                ST_IDLE: begin
                    ready_reg      <= 1'b1;
                    save_flags_reg <= flags_register;
                    save_ip_reg    <= irq_go ? ip_reg : ip_reg + 16'h0001;
                    base_reg       <= 3'h0;
                    if (int_entry) begin
                        st_reg    <= ST_PUSH;
                        len_reg   <= INT_FRAME;
                        ready_reg <= 1'b0;
                    end else if (accept) begin
                        ready_reg <= 1'b0;
                        unique case (cmd_i.op)
                            OP_CALL: begin
                                st_reg  <= ST_PUSH;
                                len_reg <= CALL_FRAME;
                            end
                            OP_PUSH_FLAGS: begin
                                st_reg   <= ST_PUSH;
                                len_reg  <= ONE_FRAME;
                                base_reg <= SLOT_FLAGS;
                            end
                            OP_POP_FLAGS, OP_RET, OP_HANDLER_RETURN: begin
                                st_reg   <= ST_POP;
                                len_reg  <= (cmd_i.op == OP_RET) ? CALL_FRAME :
                                            (cmd_i.op == OP_POP_FLAGS) ? ONE_FRAME : INT_FRAME;
                                base_reg <= (cmd_i.op == OP_RET) ? SLOT_IPH : SLOT_FLAGS;
                            end
                            default: ready_reg <= 1'b1;
                        endcase
                    end
                end
                ST_PUSH: begin
                    stk_reg.we    <= 1'b1;
                    stk_reg.addr  <= {STACK_HI, sp_reg - {3'h0, cnt_reg}};
                    stk_reg.wdata <= push_data;
                    cnt_reg       <= cnt_reg + 3'h1;
                    if (cnt_reg == len_reg - 3'h1) begin
                        st_reg    <= ST_IDLE;
                        sp_reg    <= sp_reg - {3'h0, len_reg};
                        ready_reg <= 1'b1;
                    end
                end
                ST_POP: begin
                    cnt_reg <= cnt_reg + 3'h1;
                    if (cnt_reg < len_reg) begin
                        stk_reg.re   <= 1'b1;
                        stk_reg.addr <= {STACK_HI, sp_reg + 6'h01 + {3'h0, cnt_reg}};
                        pop_v1_reg   <= 1'b1;
                        slot1_reg    <= base_reg - cnt_reg;
                    end
                    if (cnt_reg == len_reg + 3'h1) begin
                        st_reg    <= ST_IDLE;
                        sp_reg    <= sp_reg + {3'h0, len_reg};
                        ready_reg <= 1'b1;
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [4:0] nib_chk;
    assign nib_chk = {1'b0, acc_reg[3:0]} + {1'b0, cmd_i.operand[3:0]};

    a_half_carry_add: assert property (@(posedge clk) disable iff (sys_rst)
        accept & (cmd_i.op == OP_ADD) & (cmd_i.dst == DST_ACC) |=> h_reg == $past(nib_chk[4]))
        else $error("half flag wrong after add");
    a_mask_on_entry: assert property (@(posedge clk) disable iff (sys_rst)
        int_entry |=> i_reg ##1 ~ready_reg)
        else $error("mask not set on interrupt entry");
    a_neg_copy: assert property (@(posedge clk) disable iff (sys_rst)
        accept & wr_res & (cmd_i.dst == DST_ACC) |=> n_reg == acc_reg[7])
        else $error("negative flag not bit 7");
    a_zero_result: assert property (@(posedge clk) disable iff (sys_rst)
        accept & wr_res & (cmd_i.dst == DST_ACC) |=> z_reg == (acc_reg == 8'h00))
        else $error("zero flag mismatch");
    a_int_frame_len: assert property (@(posedge clk) disable iff (sys_rst)
        int_entry |-> ##2 stk_reg.we [*5] ##1 ~stk_reg.we)
        else $error("interrupt frame not five bytes");
    a_first_low_byte: assert property (@(posedge clk) disable iff (sys_rst)
        irq_go |-> ##2 (stk_reg.wdata == save_ip_reg[7:0]) && (stk_reg.addr[5:0] == sp_reg))
        else $error("first stacked byte not low pointer");
    a_y_kept_seq: assert property (@(posedge clk) disable iff (sys_rst)
        (st_reg != ST_IDLE) |=> $stable(y_reg))
        else $error("second index changed by stack sequence");
    a_pend_held: assert property (@(posedge clk) disable iff (sys_rst)
        pend_reg & i_reg |=> pend_reg)
        else $error("masked request lost");
    a_carry_set_op: assert property (@(posedge clk) disable iff (sys_rst)
        accept & (cmd_i.op == OP_SET_OVERFLOW) |=> c_reg ##1 ready_reg)
        else $error("carry set command failed");

endmodule

// File: src/cpurs_pkg.sv
package cpurs_pkg;

    // --------------------------------------------------------------
    // flags register layout and reset values
    // --------------------------------------------------------------
    localparam int           H_BIT     = 4;
    localparam int           I_BIT     = 3;
    localparam int           N_BIT     = 2;
    localparam int           Z_BIT     = 1;
    localparam int           C_BIT     = 0;
    localparam logic [2:0]   FLAGS_TOP = 3'h7;       // bits 7..5 read as ones
    localparam logic [4:0]   FLAGS_RST = 5'h08;      // only the mask set at reset
    localparam logic [7:0]   DATA_RST  = 8'h00;
    localparam logic [15:0]  IP_RST    = 16'h0000;

    // --------------------------------------------------------------
    // stack window and frame shapes
    // --------------------------------------------------------------
    localparam logic [9:0]   STACK_HI   = 10'h004;   // address bits 15..6 of the stack
    localparam logic [5:0]   SP_RST     = 6'h3F;
    localparam logic [2:0]   INT_FRAME  = 3'h5;
    localparam logic [2:0]   CALL_FRAME = 3'h2;
    localparam logic [2:0]   ONE_FRAME  = 3'h1;
    localparam logic [2:0]   SLOT_IPL   = 3'h0;      // slot order in an interrupt frame
    localparam logic [2:0]   SLOT_IPH   = 3'h1;
    localparam logic [2:0]   SLOT_X     = 3'h2;
    localparam logic [2:0]   SLOT_ACC   = 3'h3;
    localparam logic [2:0]   SLOT_FLAGS = 3'h4;

    typedef enum logic [4:0] {
        OP_NOP, OP_PREFIX, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR,
        OP_XOR, OP_LD, OP_SLL, OP_SRL, OP_RLC, OP_RRC, OP_BTST,
        OP_SET_OVERFLOW, OP_CLEAR_OVERFLOW, OP_MASK, OP_UNMASK, OP_PUSH_FLAGS,
        OP_POP_FLAGS, OP_BRANCH, OP_JUMP, OP_CALL, OP_RET, OP_TRAP,
        OP_HANDLER_RETURN
    } cpurs_op_t;

    typedef enum logic [3:0] {
        BRANCH_IF_NIBBLE_CARRY, BRANCH_IF_NO_NIBBLE_CARRY, BRANCH_IF_MASKED,
        BRANCH_IF_UNMASKED, BRANCH_IF_NEGATIVE, BRANCH_IF_POSITIVE,
        BRANCH_IF_EQUAL, BRANCH_IF_NOT_EQUAL, BRANCH_IF_OVERFLOW,
        BRANCH_IF_NO_OVERFLOW
    } cpurs_cond_t;

    typedef enum logic {DST_ACC, DST_INDEX} cpurs_dst_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PUSH = 3'b010,
        ST_POP  = 3'b100
    } cpurs_state_t;

    typedef struct packed {
        logic        valid;
        cpurs_op_t   op;
        cpurs_dst_t  dst;
        logic [7:0]  operand;   // alu operand or branch offset
        cpurs_cond_t cond;
        logic [15:0] target;    // jump/call target, bit index in [2:0]
    } cpurs_cmd_t;

    typedef struct packed {
        logic        we;
        logic        re;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cpurs_stk_t;

endpackage

// File: bench/cpurs_core_regs_bench.sv
module cpurs_core_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import cpurs_pkg::*;
    logic        clk = 0;
    logic        sys_rst = 1;
    logic        irq_req = 0;
    logic [7:0]  stack_rdata = '0;
    cpurs_cmd_t  cmd = '0;
    cpurs_stk_t  stk_o;
    logic        ready, irq_ack, branch_taken, br;
    logic [7:0]  acc_q, index_x_q, index_y_q, flags_register, sf;
    logic [15:0] instr_pointer, sip, mip = 16'h0000;
    logic [7:0]  mem [256];
    logic [31:0] wq [$];
    int          n_mismatch = 0, tests_run = 0, cyc = 0, seed = 32'h2138_4310;
    int          ma, mx, my, sa, sx, h, i = 1, n, z, c, pre, r, cin, rnd, k;
    cpurs_op_t   alu [13] = '{OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
                              OP_LD, OP_SLL, OP_SRL, OP_RLC, OP_RRC, OP_BTST};
    cpurs_op_t   ctl [5] = '{OP_SET_OVERFLOW, OP_CLEAR_OVERFLOW, OP_MASK, OP_UNMASK, OP_NOP};

    cpurs_core_regs dut (.clk(clk), .sys_rst(sys_rst), .cmd_i(cmd), .irq_req(irq_req),
        .irq_target(16'h2468), .trap_target(16'h1357), .stack_rdata(stack_rdata),
        .ready(ready), .irq_ack(irq_ack), .branch_taken(branch_taken), .stk_o(stk_o),
        .acc_q(acc_q), .index_x_q(index_x_q), .index_y_q(index_y_q),
        .instr_pointer(instr_pointer), .flags_register(flags_register));

    initial forever #10 clk = ~clk;

    // stack memory; outside a read the data lines wander so stale bytes are not trusted
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (stk_o.we) mem[stk_o.addr[7:0]] <= stk_o.wdata;
        if (stk_o.we) wq.push_back({stk_o.addr, 8'h00, stk_o.wdata});
        stack_rdata <= stk_o.re ? mem[stk_o.addr[7:0]] : ~stack_rdata;
        if (cyc > 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // reference model and checks
    // ------------------------------------------------------------
    function automatic logic [7:0] mf();
        return {3'b111, h[0], i[0], n[0], z[0], c[0]};
    endfunction

    task automatic chk(logic [63:0] got, logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic st();
        chk({acc_q, index_x_q, index_y_q, instr_pointer, flags_register},
            {ma[7:0], mx[7:0], my[7:0], mip, mf()});
    endtask

    // context save shared by hardware entry and the software trap
    task automatic enter(logic [15:0] vec);
        sf = mf();
        sip = mip;
        sa = ma;
        sx = mx;
        mip = vec;
        i = 1;
    endtask

    task automatic model(cpurs_op_t op, logic [7:0] v, cpurs_dst_t d, cpurs_cond_t cd,
                         logic [15:0] t);
        mip = mip + 16'h0001;
        cin = (op inside {OP_ADC, OP_SBC}) ? c : 0;
        case (op)
            OP_ADD, OP_ADC: r = ma + v + cin;
            OP_SUB, OP_SBC: r = ma - v - cin;
            OP_AND: r = ma & v;
            OP_OR: r = ma | v;
            OP_XOR: r = ma ^ v;
            OP_LD: r = v;
            OP_SLL, OP_RLC: r = ma * 2 + (op == OP_RLC ? c : 0);
            OP_SRL, OP_RRC: r = ma / 2 + (op == OP_RRC ? c * 128 : 0);
            OP_BTST: c = (v >> t[2:0]) & 1;
            OP_SET_OVERFLOW: c = 1;
            OP_CLEAR_OVERFLOW: c = 0;
            OP_MASK: i = 1;
            OP_UNMASK: i = 0;
            OP_PUSH_FLAGS: sf = mf();
            OP_TRAP: enter(16'h1357);
            OP_POP_FLAGS, OP_HANDLER_RETURN: begin
                {h[0], i[0], n[0], z[0], c[0]} = sf[4:0];
                if (op == OP_HANDLER_RETURN) begin
                    ma = sa;
                    mx = sx;
                    mip = sip;
                end
            end
            OP_BRANCH: begin
                r = cd[0] ^ (cd < 2 ? h : cd < 4 ? i : cd < 6 ? n : cd < 8 ? z : c);
                chk(br, r[0]);
                if (r[0]) mip = mip + {{8{v[7]}}, v};
            end
            default: ;
        endcase
        if (op inside {OP_ADD, OP_ADC}) h = (ma % 16 + v % 16 + cin) > 15;
        if (op inside {[OP_ADD:OP_SBC]}) c = r > 255 || r < 0;
        if (op inside {[OP_SLL:OP_RRC]}) c = (op inside {OP_SLL, OP_RLC}) ? ma / 128 : ma % 2;
        if (op inside {[OP_ADD:OP_RRC]}) begin
            r = r & 255;
            n = r / 128;
            z = r == 0;
            if (d == DST_ACC) ma = r;
            else if (pre != 0) my = r;
            else mx = r;
        end
        pre = op == OP_PREFIX;
    endtask

    // one command per call, driven after an idle cycle in which a pending entry can start
    task automatic issue(cpurs_op_t op, logic [7:0] v, cpurs_dst_t d = DST_ACC,
                         cpurs_cond_t cd = BRANCH_IF_EQUAL, logic [15:0] t = 16'h0000);
        for (int w = 0; w < 50 && ready !== 1'b1; w++) @(posedge clk);
        @(posedge clk);
        cmd <= '{1'b1, op, d, v, cd, t};
        @(posedge clk);
        cmd.valid <= 1'b0;
        #1 br = branch_taken;
        for (int w = 0; w < 50 && ready !== 1'b1; w++) @(posedge clk);
        #1 model(op, v, d, cd, t);
        st();
    endtask

    task automatic summarize();
        $display("mismatches=%0d compares=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 st();
        issue(OP_PREFIX, 8'h00);
        issue(OP_LD, 8'hA5, DST_INDEX);
        issue(OP_LD, 8'h3C, DST_INDEX);
        for (k = 0; k < 80; k++) begin
            rnd = $random(seed);
            issue(alu[rnd[3:0] % 13], rnd[15:8], DST_ACC, BRANCH_IF_EQUAL, rnd[31:16]);
            issue(ctl[(k / 10) % 5], 8'h00);
            issue(OP_BRANCH, rnd[23:16], DST_ACC, cpurs_cond_t'(k % 10));
        end
        issue(OP_PUSH_FLAGS, 8'h00);
        issue(OP_SET_OVERFLOW, 8'h00);
        issue(OP_POP_FLAGS, 8'h00);
        issue(OP_MASK, 8'h00);
        // request pulse launched on an edge so the design samples it cleanly
        @(posedge clk);
        irq_req <= 1'b1;
        @(posedge clk);
        irq_req <= 1'b0;
        issue(OP_LD, 8'h5A);
        issue(OP_UNMASK, 8'h00);
        wq.delete();
        enter(16'h2468);
        @(posedge clk);
        #1 chk({irq_ack, instr_pointer, flags_register[3]}, {1'b1, mip, 1'b1});
        repeat (6) @(posedge clk);
        #1 chk(wq.size(), 5);
        foreach (wq[j]) chk(wq[j], {16'h013F - 16'(j), 8'h00, j == 0 ? sip[7:0] :
            j == 1 ? sip[15:8] : j == 2 ? sx[7:0] : j == 3 ? sa[7:0] : sf});
        issue(OP_LD, 8'hFF);
        issue(OP_LD, 8'h11, DST_INDEX);
        issue(OP_HANDLER_RETURN, 8'h00);
        issue(OP_MASK, 8'h00);
        issue(OP_TRAP, 8'h00);
        issue(OP_HANDLER_RETURN, 8'h00);
        summarize();
    end
endmodule
